/* File: hdl/chain_trig_pkg.sv */
package chain_trig_pkg;

  // ==========================================================================
  // Timing of the reference grid and the re-arm interval
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned REF_PERIOD_NS = 100;
  // The grid period rounds down so a tick never comes later than the reference.
  localparam int unsigned REF_PERIOD_CYC = REF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned REARM_BASE_NS = 4000;
  localparam int unsigned REARM_PER_SAMPLE_NS = 1;

  // ==========================================================================
  // Pretrigger depth from chain position
  // ==========================================================================
  localparam int unsigned PRETRIG_BASE = 152;
  localparam int unsigned PRETRIG_STEP = 100;
  localparam int unsigned POS_WIDTH = 4;
  localparam int unsigned DEPTH_WIDTH = 12;
  localparam int unsigned CNT_WIDTH = 12;
  localparam int unsigned TIME_WIDTH = 32;
  localparam int unsigned REF_CNT_WIDTH = 4;

  // Channel sample threshold compared on the master's trigger channel.
  localparam int unsigned SAMPLE_WIDTH = 16;

  typedef enum {
    ST_IDLE,
    ST_RECORD,
    ST_REARM
  } acq_state_type;

  // Trigger report handed to readout with each record.
  typedef struct packed {
    logic valid;
    logic [TIME_WIDTH-1:0] stamp;
    logic [TIME_WIDTH-1:0] corrected;
  } trig_report_type;

endpackage

/* File: hdl/chain_trig_sync.sv */
`timescale 1ns/100ps
// Function
// - Every slave passes the incoming chain trigger on to the next unit through its chain output; the master drives it from its own trigger.
// - The master finds the system trigger by comparing one of its own sample channels.
// - A slave realigns each passing trigger to the 10 MHz grid, one 100 ns period per stage.
// - A slave keeps samples from before its own trigger so its record spans the true instant.
// - A slave at position P uses a pretrigger depth of 152 plus 100 times P samples.
// - After a record ends the unit refuses triggers for 4000 ns plus 1 ns per pretrigger sample.
// - A trigger seen during the re-arm interval is ignored and starts no record.
// - At readout each slave trigger time is corrected by the master trigger time.
module chain_trig_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic is_master,
  input wire logic [chain_trig_pkg::POS_WIDTH-1:0] chain_pos,
  input wire logic [chain_trig_pkg::SAMPLE_WIDTH-1:0] trig_sample,
  input wire logic [chain_trig_pkg::SAMPLE_WIDTH-1:0] trig_level,
  input wire logic ref_clk_in,
  input wire logic chain_in,
  input wire logic [chain_trig_pkg::CNT_WIDTH-1:0] record_len,
  input wire logic [chain_trig_pkg::TIME_WIDTH-1:0] master_stamp,
  output logic chain_out,
  output logic record_start,
  output logic recording,
  output logic [chain_trig_pkg::DEPTH_WIDTH-1:0] pretrig_depth,
  output logic rearm_busy,
  output logic trig_dropped,
  output chain_trig_pkg::trig_report_type report
);
  import chain_trig_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [1:0] chain_sync;
    logic [1:0] ref_sync;
    logic ref_prev;
    logic pending;
    logic chain_out;
    logic [REF_CNT_WIDTH-1:0] hold_cnt;
    logic sample_prev;
    acq_state_type state;
    logic [CNT_WIDTH-1:0] rec_cnt;
    logic [CNT_WIDTH:0] rearm_cnt;
    logic [DEPTH_WIDTH-1:0] depth;
    logic [TIME_WIDTH-1:0] now;
    logic record_start;
    logic recording;
    logic rearm_busy;
    logic trig_dropped;
    trig_report_type report;
  } state_type;

  state_type cur;
  state_type next_cur;

  // Reset value: idle, chain output low, nothing pending.
  localparam state_type RESET_STATE = '0;

  logic ref_tick;
  logic det_trig;
  logic above;
  logic [DEPTH_WIDTH-1:0] depth_calc;
  logic [CNT_WIDTH:0] rearm_len;

  // ==========================================================================
  // Derived values
  // ==========================================================================
  // Depth is fixed by position; the master carries no chain delay so it uses the base depth.
  always_comb begin
    if (is_master) begin
      depth_calc = DEPTH_WIDTH'(PRETRIG_BASE);
    end else begin
      depth_calc = DEPTH_WIDTH'(PRETRIG_BASE + PRETRIG_STEP * chain_pos);
    end
    // Re-arm in cycles, rounded up, since it is a least time.
    rearm_len = (CNT_WIDTH+1)'((REARM_BASE_NS + REARM_PER_SAMPLE_NS * cur.depth
                 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    above = trig_sample >= trig_level;
    ref_tick = cur.ref_sync[1] & ~cur.ref_prev;
  end

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Apart from the shift into the second stage, only the second synchroniser stage and later flops are read by any logic.
  always_comb begin
    next_cur = cur;
    next_cur.chain_sync = {cur.chain_sync[0], chain_in};
    next_cur.ref_sync = {cur.ref_sync[0], ref_clk_in};
    next_cur.ref_prev = cur.ref_sync[1];
    next_cur.sample_prev = above;
    next_cur.depth = depth_calc;
    next_cur.now = cur.now + 32'h0000_0001;
    next_cur.record_start = 1'b0;
    next_cur.trig_dropped = 1'b0;
    det_trig = 1'b0;

    if (is_master) begin
      // Rising crossing on the sampled channel is the system trigger.
      det_trig = above & ~cur.sample_prev;
      next_cur.chain_out = det_trig | (above & cur.chain_out);
    end else begin
      // Catch the chain input, launch it on the next grid edge and hold it REF_PERIOD_CYC + 1 cycles (13 cycles, 104 ns).
      if (cur.chain_sync[1] & ~cur.pending & ~cur.chain_out) begin
        next_cur.pending = 1'b1;
      end
      if (ref_tick & cur.pending) begin
        next_cur.pending = 1'b0;
        next_cur.chain_out = 1'b1;
        next_cur.hold_cnt = REF_CNT_WIDTH'(REF_PERIOD_CYC);
        det_trig = 1'b1;
      end else if (cur.hold_cnt != '0) begin
        next_cur.hold_cnt = cur.hold_cnt - 4'h1;
      end else begin
        next_cur.chain_out = 1'b0;
      end
    end

    // Acquisition and re-arm sequence.
    case (cur.state)
      ST_IDLE: begin
        if (det_trig) begin
          next_cur.state = ST_RECORD;
          next_cur.record_start = 1'b1;
          next_cur.recording = 1'b1;
          next_cur.rec_cnt = record_len;
          next_cur.report.valid = 1'b1;
          // Stamp is backed off by the pretrigger depth so it names the true instant.
          next_cur.report.stamp = cur.now - TIME_WIDTH'(cur.depth);
          next_cur.report.corrected = cur.now - master_stamp;
        end
      end
      ST_RECORD: begin
        if (cur.rec_cnt <= 12'h001) begin
          next_cur.state = ST_REARM;
          next_cur.recording = 1'b0;
          next_cur.rearm_busy = 1'b1;
          next_cur.rearm_cnt = rearm_len;
        end else begin
          next_cur.rec_cnt = cur.rec_cnt - 12'h001;
        end
        next_cur.trig_dropped = det_trig;
      end
      ST_REARM: begin
        // Triggers here are counted as dropped and never remembered.
        next_cur.trig_dropped = det_trig;
        if (cur.rearm_cnt <= 13'h0001) begin
          next_cur.state = ST_IDLE;
          next_cur.rearm_busy = 1'b0;
        end else begin
          next_cur.rearm_cnt = cur.rearm_cnt - 13'h0001;
        end
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur <= RESET_STATE;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs come straight from the state flops.
  assign chain_out = cur.chain_out;
  assign record_start = cur.record_start;
  assign recording = cur.recording;
  assign pretrig_depth = cur.depth;
  assign rearm_busy = cur.rearm_busy;
  assign trig_dropped = cur.trig_dropped;
  assign report = cur.report;

endmodule // chain_trig_sync

/* File: test/chain_trig_asserts.sv */
`timescale 1ns/100ps
// ==========
// Port checker for the chain trigger block
// ==========
module chain_trig_asserts
  import chain_trig_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic is_master,
  input wire logic [POS_WIDTH-1:0] chain_pos,
  input wire logic [SAMPLE_WIDTH-1:0] trig_sample,
  input wire logic [SAMPLE_WIDTH-1:0] trig_level,
  input wire logic [TIME_WIDTH-1:0] master_stamp,
  input wire logic chain_out,
  input wire logic record_start,
  input wire logic recording,
  input wire logic [DEPTH_WIDTH-1:0] pretrig_depth,
  input wire logic rearm_busy,
  input wire logic trig_dropped,
  input trig_report_type report
);
  logic [11:0] busy_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Length of the current re-arm run, so its end can be judged against the depth.
  always_ff @(posedge clk_sys) begin
    busy_cnt <= (rst || !rearm_busy) ? 12'h000 : busy_cnt + 12'h001;
  end
  sequence held_13;
    chain_out[*8] ##1 chain_out[*5];
  endsequence
  fwd_out_a: assert property (record_start |-> chain_out)
    else $error("record began without forwarding");
  master_cross_a: assert property (is_master && record_start |->
    $past(trig_sample) >= $past(trig_level)) else $error("master start without crossing");
  slave_hold_a: assert property (!is_master && $rose(chain_out) |-> held_13 ##1 !chain_out)
    else $error("slave forward width wrong");
  slave_depth_a: assert property (!is_master && !$past(rst) |->
    pretrig_depth == DEPTH_WIDTH'(PRETRIG_BASE + PRETRIG_STEP * chain_pos))
    else $error("slave depth wrong");
  rec_rearm_a: assert property ($fell(recording) |-> rearm_busy)
    else $error("no re-arm after record");
  rearm_len_a: assert property ($fell(rearm_busy) |-> busy_cnt -
    (REARM_BASE_NS + pretrig_depth + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS <= 1)
    else $error("re-arm length wrong");
  arm_start_a: assert property (record_start |-> !$past(recording) && !$past(rearm_busy))
    else $error("start while not armed");
  drop_cause_a: assert property (trig_dropped |->
    !record_start && ($past(recording) || $past(rearm_busy)))
    else $error("drop while armed");
  corr_a: assert property (record_start |-> report.valid &&
    report.corrected - report.stamp == TIME_WIDTH'(pretrig_depth) - master_stamp)
    else $error("report correction wrong");
endmodule // chain_trig_asserts

bind chain_trig_sync chain_trig_asserts chain_trig_asserts_i (.clk_sys(clk_sys), .rst(rst),
  .is_master(is_master), .chain_pos(chain_pos), .trig_sample(trig_sample),
  .trig_level(trig_level), .master_stamp(master_stamp), .chain_out(chain_out),
  .record_start(record_start), .recording(recording), .pretrig_depth(pretrig_depth),
  .rearm_busy(rearm_busy), .trig_dropped(trig_dropped), .report(report));

/* File: test/chain_neighbour.sv */
`timescale 1ns/100ps
// ==========
// Previous unit of the chain and the shared reference
// ==========
module chain_neighbour (
  input wire logic fire,
  output logic ref_clk_in,
  output logic chain_in
);
  // The reference runs free at 10 MHz, offset so it has no phase tie to the system clock.
  initial begin
    ref_clk_in = 1'b0;
    #3;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  // One forwarded trigger, 13 cycles wide; the line idles low between triggers.
  initial chain_in = 1'b0;
  always @(posedge fire) begin
    chain_in = 1'b1;
    #104 chain_in = 1'b0;
  end
endmodule // chain_neighbour

/* File: test/testbench.sv */
`timescale 1ns/100ps
// ==========
// Self-checking bench for the chain trigger block
// ==========
module testbench;
  import chain_trig_pkg::*;
  logic clk_sys, rst, is_master, fire, ref_clk_in, chain_in, chain_out;
  logic record_start, recording, rearm_busy, trig_dropped;
  logic [POS_WIDTH-1:0] chain_pos;
  logic [SAMPLE_WIDTH-1:0] trig_sample;
  logic [DEPTH_WIDTH-1:0] pretrig_depth;
  trig_report_type report;
  int num_errors = 0, tests_run = 0, cycles = 0, n_start, n_drop, waited;
  int busy_run = 0, busy_len = 0;
  localparam logic [31:0] MSTAMP = 32'h0000_0100;
  chain_trig_sync chain_trig_sync_i (.clk_sys(clk_sys), .rst(rst), .is_master(is_master),
    .chain_pos(chain_pos), .trig_sample(trig_sample), .trig_level(16'h4000),
    .ref_clk_in(ref_clk_in), .chain_in(chain_in), .record_len(12'h040),
    .master_stamp(MSTAMP), .chain_out(chain_out), .record_start(record_start),
    .recording(recording), .pretrig_depth(pretrig_depth), .rearm_busy(rearm_busy),
    .trig_dropped(trig_dropped), .report(report));
  chain_neighbour chain_neighbour_i (.fire(fire), .ref_clk_in(ref_clk_in), .chain_in(chain_in));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Event counts and the hang limit; a run should need about 2700 cycles.
  always @(posedge clk_sys) begin
    cycles++;
    n_start += (record_start === 1'b1);
    n_drop += (trig_dropped === 1'b1);
    // Length of the last re-arm run, kept so it can be held against the depth.
    if (rearm_busy === 1'b1) busy_run++;
    else if (busy_run != 0) begin
      busy_len = busy_run;
      busy_run = 0;
    end
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic m, input logic [POS_WIDTH-1:0] p);
    rst = 1'b1;
    is_master = m;
    chain_pos = p;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    n_start = 0;
    n_drop = 0;
  endtask
  // Both waits are bounded so a dead block shows up as a failed compare.
  task automatic wait_start();
    for (waited = 0; record_start !== 1'b1 && waited < 40; waited++) @(negedge clk_sys);
  endtask
  task automatic wait_armed();
    for (waited = 0; (recording | rearm_busy) !== 1'b0 && waited < 1000; waited++)
      @(negedge clk_sys);
  endtask
  task automatic run_master();
    do_reset(1'b1, '0);
    check(pretrig_depth, PRETRIG_BASE);
    trig_sample = 16'h4001;
    wait_start();
    check(record_start, 1);
    check(chain_out, 1);
    check(report.corrected - report.stamp, PRETRIG_BASE - MSTAMP);
    // Five fresh crossings all land in the re-arm time, after the 64-cycle record has ended.
    repeat (5) begin
      trig_sample = '0;
      repeat (100) @(negedge clk_sys);
      trig_sample = 16'h4001;
      repeat (4) @(negedge clk_sys);
    end
    wait_armed();
    repeat (20) @(negedge clk_sys);
    check(busy_len, (REARM_BASE_NS + PRETRIG_BASE + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    check(n_start, 1);
    check(n_drop, 5);
    trig_sample = '0;
  endtask
  task automatic run_slave(input logic [POS_WIDTH-1:0] p);
    do_reset(1'b0, p);
    check(pretrig_depth, PRETRIG_BASE + PRETRIG_STEP * p);
    fire = 1'b1;
    wait_start();
    fire = 1'b0;
    check(waited >= 3 && waited <= 20, 1);
    check(report.corrected - report.stamp, PRETRIG_BASE + PRETRIG_STEP * p - MSTAMP);
    repeat (100) @(negedge clk_sys);
    fire = 1'b1;
    repeat (20) @(negedge clk_sys);
    fire = 1'b0;
    wait_armed();
    @(negedge clk_sys);
    check(busy_len, (REARM_BASE_NS + PRETRIG_BASE + PRETRIG_STEP * p + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS);
    check(n_start, 1);
    check(n_drop, 1);
    fire = 1'b1;
    wait_start();
    fire = 1'b0;
    check(record_start, 1);
    // Let the chain input go idle, or the next reset would catch the tail of this pulse.
    repeat (20) @(negedge clk_sys);
  endtask
  initial begin
    rst = 1'b1;
    is_master = 1'b1;
    chain_pos = '0;
    trig_sample = '0;
    fire = 1'b0;
    run_master();
    run_slave(4'h0);
    run_slave(4'h1);
    run_slave(4'hf);
    tally_and_finish();
  end
endmodule // testbench
